/* File: oem_map.svh */
// register offsets, field positions, reset values and timing counts of the output control block
`ifndef OEM_MAP_SVH
`define OEM_MAP_SVH
// ********************
// register byte offsets
// ********************
`define OEM_CMD_OFS 8'h00
`define OEM_CFG_OFS 8'h04
`define OEM_VLIM_OFS 8'h08
`define OEM_CLIM_OFS 8'h0c
`define OEM_SLOT_OFS 8'h10
`define OEM_STAT_OFS 8'h14
`define OEM_VEFF_OFS 8'h18
`define OEM_CEFF_OFS 8'h1c
// ********************
// field positions
// ********************
`define OEM_CMD_ON_BIT 0
`define OEM_CMD_OFF_BIT 1
`define OEM_CMD_SAVE_BIT 2
`define OEM_CFG_VREF_BIT 6
`define OEM_CFG_CREF_BIT 7
`define OEM_LIM_W 16
// ********************
// reset values and timing
// ********************
`define OEM_PIN_RST 3'b110
`define OEM_LIM_RST 16'h0000
`define OEM_CLK_MHZ 250
`define OEM_PULSE_US 100
`define OEM_OFF_DELAY_MS 200
`define OEM_RESP_OKAY 2'h0
`define OEM_RESP_SLVERR 2'h2
`endif

/* File: oem_pkg.sv */
// types of the output control block
package oem_pkg;
  typedef enum logic [1:0] {OEM_SRC_TRIG = 2'h0, OEM_SRC_STBY = 2'h1, OEM_SRC_HOST = 2'h2}
    oem_out_src_t;
  typedef enum logic [1:0] {OEM_MM_VOLT = 2'h0, OEM_MM_CURR = 2'h1, OEM_MM_EXT = 2'h2}
    oem_main_mode_t;
  typedef enum logic [1:0] {OEM_PS_FIXED = 2'h0, OEM_PS_EXT = 2'h1, OEM_PS_LESS = 2'h2}
    oem_prot_src_t;
  // gray path: wait -> load -> run
  typedef enum logic [1:0] {OEM_PU_WAIT = 2'h0, OEM_PU_LOAD = 2'h1, OEM_PU_RUN = 2'h3}
    oem_pu_state_t;
endpackage

/* File: oem_ctrl.sv */
// output enable, main channel mode and protect limit source control with an axi4-lite slave
`include "oem_map.svh"
module oem_ctrl
  import oem_pkg::*;
#(
  parameter int PULSE_CYC = `OEM_PULSE_US * `OEM_CLK_MHZ,
  parameter logic [`OEM_LIM_W-1:0] RATED_V = 16'h2710,
  parameter logic [`OEM_LIM_W-1:0] RATED_I = 16'h2710,
  parameter logic [`OEM_LIM_W-1:0] MIN_BOX_V = 16'h03e8,
  parameter logic [`OEM_LIM_W-1:0] MIN_BOX_I = 16'h03e8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic nv_rst,
  // pins: shutdown (high = shut down), trigger on/off, analog mode, switch bank
  input wire logic shutdown_pin,
  input wire logic trigger_on_off_pin,
  input wire logic analog_mode_pin,
  input wire logic [4:0] power_up_switch_bank,
  // analog limit inputs after conversion: v+, v-, c+, c- magnitudes
  input wire logic [4*`OEM_LIM_W-1:0] ext_lim_in,
  // power stage and indicators
  output logic out_enable,
  output logic power_stage_off,
  output logic fault_led,
  output logic output_led,
  output logic mode_current,
  output logic vref_ext,
  output logic cref_ext,
  output logic [4*`OEM_LIM_W-1:0] prot_lim_eff,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LW = `OEM_LIM_W;
  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [2:0] PIN_RST = `OEM_PIN_RST;
  localparam logic [LW-1:0] MAX_V = LW'(RATED_V + RATED_V / 100);
  localparam logic [LW-1:0] MAX_I = LW'(RATED_I + RATED_I / 100);

  // ********************
  // pin synchronisers and pulse width filters
  // ********************
  logic [2:0] pin_raw;
  logic [2:0] pin_flt;
  assign pin_raw = {analog_mode_pin, trigger_on_off_pin, shutdown_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic s1, s2, s3;
      logic [CW-1:0] cnt;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          s1 <= PIN_RST[gi];
          s2 <= PIN_RST[gi];
          s3 <= PIN_RST[gi];
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // a level only counts once it stood for the minimum pulse width
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cnt <= '0;
          pin_flt[gi] <= PIN_RST[gi];
        end else if (s2 != s3 || s3 == pin_flt[gi]) begin
          cnt <= '0;
        end else if (cnt == CW'(PULSE_CYC - 1)) begin
          cnt <= '0;
          pin_flt[gi] <= s3;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate
  logic shut_f, trig_f, amode_f, trig_f_d;
  assign shut_f = pin_flt[0];
  assign trig_f = pin_flt[1];
  assign amode_f = pin_flt[2];

  // switch bank is a strap: synchronised, captured once after reset release;
  // the chain runs through reset so the capture never sees a cleared stale value
  logic [4:0] sw1, sw2, sw3, sw;
  always_ff @(posedge clk_sys) begin
    sw1 <= power_up_switch_bank;
    sw2 <= sw1;
    sw3 <= sw2;
  end

  // ********************
  // configuration registers and saved slots
  // ********************
  oem_pu_state_t pu;
  oem_out_src_t out_src, nv_out_src;
  oem_main_mode_t mmode;
  oem_prot_src_t vsrc, csrc;
  logic trig_inv, shut_lat;
  logic [4*LW-1:0] dig_lim;
  logic [4*LW-1:0] slot_lim [16];
  logic slot_cur [16];
  logic wr_go, cmd_on, cmd_off, cmd_save, slot_we;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [3:0] slot_idx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pu <= OEM_PU_WAIT;
    end else begin
      case (pu)
        OEM_PU_WAIT: if (sw2 == sw3) pu <= OEM_PU_LOAD;
        OEM_PU_LOAD: pu <= OEM_PU_RUN;
        OEM_PU_RUN: pu <= OEM_PU_RUN;
        default: pu <= OEM_PU_WAIT;
      endcase
    end
  end

  // power-up load from switches, then host writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sw <= 5'h00;
      trig_inv <= 1'b0;
      out_src <= OEM_SRC_TRIG;
      mmode <= OEM_MM_EXT;
      vsrc <= OEM_PS_EXT;
      csrc <= OEM_PS_EXT;
      vref_ext <= 1'b1;
      cref_ext <= 1'b1;
      dig_lim <= {4{`OEM_LIM_RST}};
    end else if (pu == OEM_PU_WAIT && sw2 == sw3) begin
      sw <= sw3;
    end else if (pu == OEM_PU_LOAD) begin
      trig_inv <= !sw[4];
      out_src <= nv_out_src;
      vref_ext <= (sw == 5'h00) || (sw[1] && sw[4]);
      cref_ext <= (sw == 5'h00) || (sw[1] && sw[4]);
      if (sw == 5'h00) begin
        mmode <= OEM_MM_EXT;
      end else if (!sw[4]) begin
        mmode <= slot_cur[sw[3:0]] ? OEM_MM_CURR : OEM_MM_VOLT;
      end else begin
        mmode <= sw[0] ? OEM_MM_VOLT : OEM_MM_CURR;
      end
      if (sw == 5'h00 || sw[4:2] == 3'b100) begin
        vsrc <= OEM_PS_EXT;
        csrc <= OEM_PS_EXT;
      end else begin
        vsrc <= OEM_PS_FIXED;
        csrc <= OEM_PS_FIXED;
        case (sw[4:2])
          3'b101: dig_lim <= {MAX_I, MIN_BOX_I, MAX_V, MIN_BOX_V};
          3'b110: dig_lim <= {MIN_BOX_I, MAX_I, MIN_BOX_V, MAX_V};
          3'b111: dig_lim <= {MAX_I, MAX_I, MAX_V, MAX_V};
          default: dig_lim <= slot_lim[sw[3:0]];
        endcase
      end
    end else if (wr_go) begin
      case (aw_addr)
        `OEM_CFG_OFS: begin
          if (w_strb[0]) begin
            if (w_data[1:0] != 2'h3) mmode <= oem_main_mode_t'(w_data[1:0]);
            if (w_data[3:2] != 2'h3) vsrc <= oem_prot_src_t'(w_data[3:2]);
            if (w_data[5:4] != 2'h3) csrc <= oem_prot_src_t'(w_data[5:4]);
            vref_ext <= w_data[`OEM_CFG_VREF_BIT];
            cref_ext <= w_data[`OEM_CFG_CREF_BIT];
          end
          if (w_strb[1] && w_data[9:8] != 2'h3) out_src <= oem_out_src_t'(w_data[9:8]);
        end
        `OEM_VLIM_OFS: dig_lim[0 +: 32] <= merge(dig_lim[0 +: 32], w_data, w_strb);
        `OEM_CLIM_OFS: dig_lim[32 +: 32] <= merge(dig_lim[32 +: 32], w_data, w_strb);
        default: ;
      endcase
    end
  end

  // slots and saved control source model non-volatile store: only nv_rst clears them
  always_ff @(posedge clk_sys) begin
    if (nv_rst) begin
      nv_out_src <= OEM_SRC_TRIG;
      for (int k = 0; k < 16; k++) begin
        slot_lim[k] <= {4{`OEM_LIM_RST}};
        slot_cur[k] <= 1'b0;
      end
    end else begin
      if (cmd_save) nv_out_src <= out_src;
      if (slot_we && slot_idx != 4'h0) begin
        slot_lim[slot_idx] <= dig_lim;
        slot_cur[slot_idx] <= mode_current;
      end
    end
  end

  // ********************
  // output enable and shutdown
  // ********************
  logic trig_off;
  assign trig_off = trig_inv ? trig_f : !trig_f;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shut_lat <= 1'b0;
      power_stage_off <= 1'b0;
      fault_led <= 1'b0;
      trig_f_d <= 1'b1;
    end else begin
      trig_f_d <= trig_f;
      if (shut_f) begin
        shut_lat <= 1'b1;
        power_stage_off <= 1'b1;
        fault_led <= 1'b1;
      end
    end
  end

  // output light is a twin flop so both outputs stay register driven
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_enable <= 1'b0;
      output_led <= 1'b0;
    end else if (shut_lat || shut_f || pu != OEM_PU_RUN) begin
      out_enable <= 1'b0;
      output_led <= 1'b0;
    end else begin
      case (out_src)
        OEM_SRC_TRIG: begin
          out_enable <= !trig_off;
          output_led <= !trig_off;
        end
        OEM_SRC_STBY: begin
          if (trig_f_d && !trig_f) begin
            out_enable <= 1'b0;
            output_led <= 1'b0;
          end else if (cmd_on) begin
            out_enable <= 1'b1;
            output_led <= 1'b1;
          end
        end
        default: begin
          if (cmd_off) begin
            out_enable <= 1'b0;
            output_led <= 1'b0;
          end else if (cmd_on) begin
            out_enable <= 1'b1;
            output_led <= 1'b1;
          end
        end
      endcase
    end
  end

  // ********************
  // main channel mode and effective protect limits
  // ********************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_current <= 1'b0;
    end else begin
      mode_current <= (mmode == OEM_MM_EXT) ? !amode_f : (mmode == OEM_MM_CURR);
    end
  end
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lim
      logic [LW-1:0] d, a;
      oem_prot_src_t s;
      assign d = dig_lim[gi*LW +: LW];
      assign a = ext_lim_in[gi*LW +: LW];
      assign s = (gi < 2) ? vsrc : csrc;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          prot_lim_eff[gi*LW +: LW] <= `OEM_LIM_RST;
        end else begin
          case (s)
            OEM_PS_EXT: prot_lim_eff[gi*LW +: LW] <= a;
            OEM_PS_LESS: prot_lim_eff[gi*LW +: LW] <= (d < a) ? d : a;
            default: prot_lim_eff[gi*LW +: LW] <= d;
          endcase
        end
      end
    end
  endgenerate

  // ********************
  // axi4-lite slave
  // ********************
  logic aw_hold, w_hold;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign cmd_on = wr_go && aw_addr == `OEM_CMD_OFS && w_strb[0] && w_data[`OEM_CMD_ON_BIT];
  assign cmd_off = wr_go && aw_addr == `OEM_CMD_OFS && w_strb[0] && w_data[`OEM_CMD_OFF_BIT];
  assign cmd_save = wr_go && aw_addr == `OEM_CMD_OFS && w_strb[0] && w_data[`OEM_CMD_SAVE_BIT];
  assign slot_we = wr_go && aw_addr == `OEM_SLOT_OFS && w_strb[0];
  assign slot_idx = w_data[3:0];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OEM_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `OEM_SLOT_OFS) ? `OEM_RESP_SLVERR : `OEM_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `OEM_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `OEM_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OEM_CMD_OFS, `OEM_SLOT_OFS: s_axi_rdata <= 32'h0000_0000;
        `OEM_CFG_OFS: s_axi_rdata <= {22'h0, out_src, cref_ext, vref_ext, csrc, vsrc, mmode};
        `OEM_VLIM_OFS: s_axi_rdata <= dig_lim[0 +: 32];
        `OEM_CLIM_OFS: s_axi_rdata <= dig_lim[32 +: 32];
        `OEM_STAT_OFS: s_axi_rdata <= {21'h0, pu == OEM_PU_RUN, sw, trig_inv, mode_current,
                                       fault_led, shut_lat, out_enable};
        `OEM_VEFF_OFS: s_axi_rdata <= prot_lim_eff[0 +: 32];
        `OEM_CEFF_OFS: s_axi_rdata <= prot_lim_eff[32 +: 32];
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `OEM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************
  // assertions
  // ********************
  property p_shut_latch;
    @(posedge clk_sys) disable iff (sys_rst) shut_f |=> shut_lat && power_stage_off;
  endproperty
  a_shut_latch: assert property (p_shut_latch) else $error("shutdown not latched");
  property p_shut_hold;
    @(posedge clk_sys) disable iff (sys_rst) shut_lat |=> shut_lat && fault_led;
  endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown latch released");
  property p_no_out_shut;
    @(posedge clk_sys) disable iff (sys_rst) shut_lat |-> ##1 !out_enable [*3];
  endproperty
  a_no_out_shut: assert property (p_no_out_shut) else $error("output on while shut");
  property p_trig_follow;
    @(posedge clk_sys) disable iff (sys_rst)
      (pu == OEM_PU_RUN && out_src == OEM_SRC_TRIG && !shut_lat && !shut_f)
      |=> out_enable == !$past(trig_off) && output_led == out_enable;
  endproperty
  a_trig_follow: assert property (p_trig_follow) else $error("trigger not followed");
  property p_stby_off;
    @(posedge clk_sys) disable iff (sys_rst)
      (pu == OEM_PU_RUN && out_src == OEM_SRC_STBY && $fell(trig_f)) |=> !out_enable;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("low pulse did not turn off");
  property p_stby_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (pu == OEM_PU_RUN && out_src == OEM_SRC_STBY && out_enable && trig_f && !shut_f)
      |=> out_enable;
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("high trigger changed output");
  property p_pol;
    @(posedge clk_sys) disable iff (sys_rst) pu == OEM_PU_LOAD |=> trig_inv == !$past(sw[4]);
  endproperty
  a_pol: assert property (p_pol) else $error("trigger polarity wrong");
  property p_mode_sw;
    @(posedge clk_sys) disable iff (sys_rst)
      (pu == OEM_PU_LOAD && sw[4]) |=> ##1 mode_current == !$past(sw[0], 2);
  endproperty
  a_mode_sw: assert property (p_mode_sw) else $error("switch mode wrong");
  property p_less;
    @(posedge clk_sys) disable iff (sys_rst)
      vsrc == OEM_PS_LESS |=> prot_lim_eff[0 +: LW] <= $past(ext_lim_in[0 +: LW]);
  endproperty
  a_less: assert property (p_less) else $error("lesser limit exceeded");
  property p_ext_lim;
    @(posedge clk_sys) disable iff (sys_rst)
      csrc == OEM_PS_EXT |=> prot_lim_eff[2*LW +: LW] == $past(ext_lim_in[2*LW +: LW]);
  endproperty
  a_ext_lim: assert property (p_ext_lim) else $error("external limit not followed");
  c_shut: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(shut_lat));
  c_stby: cover property (@(posedge clk_sys) disable iff (sys_rst)
    out_src == OEM_SRC_STBY && $fell(out_enable));
  c_host_on: cover property (@(posedge clk_sys) disable iff (sys_rst)
    out_src == OEM_SRC_HOST && cmd_on);
  c_save: cover property (@(posedge clk_sys) disable iff (sys_rst) cmd_save);
endmodule

/* File: oem_pin_drv.sv */
// pin driver standing in for the external controller: trigger and shutdown pins
module oem_pin_drv #(
  parameter int WIDTH = 12
) (
  // clock
  input wire logic clk_sys,
  // bench requests: start a pulse, aim it at the shutdown pin, trigger rest level
  input wire logic go,
  input wire logic sel_shut,
  input wire logic trig_lvl,
  // pins of the device
  output logic shutdown_pin,
  output logic trigger_on_off_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic on_shut = 1'b0;
  // pulses outlast the minimum width, so the device filter must accept every one
  always @(posedge clk_sys) begin
    if (go) begin
      cnt <= WIDTH;
      on_shut <= sel_shut;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign shutdown_pin = (cnt != 0) && on_shut;
  assign trigger_on_off_pin = (cnt != 0 && !on_shut) ? 1'b0 : trig_lvl;
endmodule

/* File: tb_oem_ctrl.sv */
// self-checking bench of the output control block with its pin driver
`include "oem_map.svh"
module tb_oem_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 8;
  localparam logic [63:0] EXT = 64'h4444_3333_2222_1111;
  typedef struct packed {
    logic [4:0] sw;
    logic am;
    logic tg;
    logic [2:0] exp;
    logic [63:0] lim;
  } oem_row_t;
  // switches, mode pin, trigger; expected {out, current mode, refs}, limits
  oem_row_t rows [7] = '{
    '{5'h00, 1'b1, 1'b0, 3'b101, EXT},
    '{5'h00, 1'b0, 1'b1, 3'b011, EXT},
    '{5'h11, 1'b1, 1'b1, 3'b100, EXT},
    '{5'h12, 1'b1, 1'b0, 3'b011, EXT},
    '{5'h15, 1'b1, 1'b1, 3'b100, 64'h2774_03e8_2774_03e8},
    '{5'h18, 1'b1, 1'b1, 3'b110, 64'h03e8_2774_03e8_2774},
    '{5'h1d, 1'b1, 1'b1, 3'b100, 64'h2774_2774_2774_2774}
  };
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic nv_rst = 1'b1;
  logic go = 1'b0, sel_shut = 1'b0, trig = 1'b1, amode = 1'b1;
  logic [4:0] sw = 5'h00;
  logic shut_pin, trig_pin, out_en, stage_off, fault, led, mcur, vref, cref;
  logic [63:0] lim;
  logic [63:0] ext_lim = EXT;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  int fails = 0, n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  oem_ctrl #(.PULSE_CYC(PC)) u_oem_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .nv_rst(nv_rst),
    .shutdown_pin(shut_pin), .trigger_on_off_pin(trig_pin), .analog_mode_pin(amode),
    .power_up_switch_bank(sw), .ext_lim_in(ext_lim),
    .out_enable(out_en), .power_stage_off(stage_off), .fault_led(fault), .output_led(led),
    .mode_current(mcur), .vref_ext(vref), .cref_ext(cref), .prot_lim_eff(lim),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  oem_pin_drv #(.WIDTH(PC + 4)) u_oem_pin_drv (
    .clk_sys(clk_sys), .go(go), .sel_shut(sel_shut), .trig_lvl(trig),
    .shutdown_pin(shut_pin), .trigger_on_off_pin(trig_pin)
  );
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rsp = bresp;
    bready <= 1'b0;
    // effects of a command land no more than one cycle after the response
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic power_up(input logic [4:0] s);
    sw <= s;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    nv_rst <= 1'b0;
    // covers switch sync, the load sequence and the pin filters
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic s);
    go <= 1'b1;
    sel_shut <= s;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (30) @(posedge clk_sys);
  endtask
  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    @(posedge clk_sys);
    foreach (rows[i]) begin
      amode <= rows[i].am;
      trig <= rows[i].tg;
      power_up(rows[i].sw);
      chk({out_en, led, stage_off}, {rows[i].exp[2], rows[i].exp[2], 1'b0});
      chk(mcur, rows[i].exp[1]);
      chk({vref, cref}, {2{rows[i].exp[0]}});
      chk(lim, rows[i].lim);
    end
    axi_wr(`OEM_CFG_OFS, 32'h51);
    chk({mcur, vref, cref}, 3'b110);
    axi_wr(`OEM_VLIM_OFS, 32'h0100_9000);
    axi_wr(`OEM_CLIM_OFS, 32'h0500_0200);
    chk(lim, {EXT[63:32], 32'h0100_9000});
    axi_wr(`OEM_CFG_OFS, 32'h2a);
    chk(lim, 64'h0500_0200_0100_1111);
    ext_lim <= 64'h0400_0300_0050_1111;
    repeat (3) @(posedge clk_sys);
    chk(lim, 64'h0400_0200_0050_1111);
    chk(mcur, 1'b0);
    amode <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(mcur, 1'b1);
    axi_wr(`OEM_CMD_OFS, 32'h2);
    chk(out_en, 1'b1);
    axi_rd(`OEM_CFG_OFS);
    chk({rsp, rd}, {`OEM_RESP_OKAY, 32'h2a});
    axi_wr(`OEM_CFG_OFS, 32'h12a);
    axi_wr(`OEM_CMD_OFS, 32'h1);
    chk(out_en, 1'b1);
    pulse(1'b0);
    chk(out_en, 1'b0);
    axi_wr(`OEM_CMD_OFS, 32'h1);
    chk(out_en, 1'b1);
    axi_wr(`OEM_CFG_OFS, 32'h22a);
    trig <= 1'b0;
    axi_wr(`OEM_CMD_OFS, 32'h2);
    chk(out_en, 1'b0);
    axi_wr(`OEM_CMD_OFS, 32'h1);
    repeat (30) @(posedge clk_sys);
    chk(out_en, 1'b1);
    trig <= 1'b1;
    axi_rd(8'h20);
    chk({rsp, rd}, {`OEM_RESP_SLVERR, 32'h0});
    axi_wr(`OEM_VEFF_OFS, 32'h1);
    chk(rsp, `OEM_RESP_SLVERR);
    axi_rd(`OEM_STAT_OFS);
    chk(rd[1:0], 2'b01);
    axi_wr(`OEM_CFG_OFS, 32'h201);
    axi_wr(`OEM_SLOT_OFS, 32'h3);
    power_up(5'h03);
    chk({mcur, lim}, {1'b1, 64'h0500_0200_0100_9000});
    axi_wr(`OEM_CFG_OFS, 32'h200);
    axi_wr(`OEM_CMD_OFS, 32'h4);
    power_up(5'h11);
    chk(out_en, 1'b0);
    axi_rd(`OEM_CFG_OFS);
    chk(rd[9:8], 2'h2);
    axi_wr(`OEM_CMD_OFS, 32'h1);
    chk(out_en, 1'b1);
    pulse(1'b1);
    chk({stage_off, fault, out_en}, 3'b110);
    axi_wr(`OEM_CMD_OFS, 32'h1);
    chk(out_en, 1'b0);
    power_up(5'h11);
    chk({stage_off, fault}, 2'b00);
    complete_run();
  end
  // the whole sequence needs about 800 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
